// File: src/tsa_i2c_slave.sv
// Two-wire slave interface, limit registers and open-drain alert of a temperature sensor.
// Assumes scl/sda/strap come from pins (async) and the conversion engine shares ref_clk.
`timescale 1ns/100ps

// How it works
// - Enabled alert activates when the loaded temperature exceeds the upper limit.
// - Enabled alert deactivates when the loaded temperature is below the lower limit.
// - Each limit is an 8-bit read/write register, one degree per step.
// - Bus address upper four bits are fixed at 1001.
// - Address select strap (ground, supply, floating) picks one of three low parts.
// - A falling data edge while clock high starts a transfer; expect address.
// - After start, eight bits shift in: address MSB first, then direction.
// - On match, pull data low before the ninth clock; otherwise stay idle.
// - Direction 0 means master writes, 1 means master reads.
// - Nine clocks per byte; data changes only while clock is low.
// - Any byte count per transfer; direction fixed by the address byte.
// - Address plus pointer byte only updates the pointer, no data register.
// - Data byte after pointer is stored into configuration or a limit.
// - Pointer persists across transfers until rewritten.
// - Configuration and limits read one byte; temperature reads two bytes.
// - Bit D4 selects alert polarity; D5 set disables alerting.
// - Alert clears on configuration write with D3 set, or under lower limit.
// - Alert output is open-drain for wired-AND sharing.
// - Acknowledge alert response address only while alerting; lose arbitration gracefully.
// - Reset: pointer to temperature, upper 7Fh, lower 80h, configuration 40h.
// - Two low pointer bits select temperature, configuration, upper, lower.
// - Temperature is 10-bit twos complement, high bits in first byte.
// - Over and under flags clear on second temperature byte, then re-set.
module tsa_i2c_slave #(
  parameter logic [2:0] ADDR_LO_GND   = 3'h0,
  parameter logic [2:0] ADDR_LO_VDD   = 3'h1,
  parameter logic [2:0] ADDR_LO_FLOAT = 3'h2
) (
  input  wire logic                       ref_clk,
  input  wire logic                       arst_n,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe,
  input  wire logic [1:0]                 addr_select_pin,
  input  wire logic [tsa_pkg::TEMP_W-1:0] temp_code,
  input  wire logic                       temp_load,
  output logic                            alert_o,
  output logic                            alert_oe
);

  // Pin synchronisers: bit 0 scl, bit 1 sda, bits 3:2 strap
  logic [3:0]          meta_q;
  logic [3:0]          sync_q;
  logic                scl_prev_q;
  logic                sda_prev_q;
  logic                scl_s;
  logic                sda_s;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;

  tsa_pkg::tsa_state_t st_q;
  logic [3:0]          bit_cnt_q;
  logic [7:0]          rx_q;
  logic [7:0]          tx_q;
  logic                rd_q;
  logic                ara_q;
  logic                first_q;
  logic                second_q;
  logic                ack_q;
  logic                sda_oe_q;
  logic                sda_o_q;

  logic [1:0]                 ptr_q;
  logic [7:0]                 cfg_q;
  logic [7:0]                 upper_temp_limit_q;
  logic [7:0]                 lower_temp_limit_q;
  logic [tsa_pkg::TEMP_W-1:0] temp_q;
  logic                       alert_q;
  logic                       over_limit_bit_q;
  logic                       under_limit_bit_q;
  logic                       alert_oe_q;
  logic                       alert_o_q;

  logic [6:0] own_addr;
  logic       addr_match;
  logic       ara_match;
  logic       ptr_wr;
  logic       data_wr;
  logic       load_evt;
  logic       rd_temp2;
  logic       temp_take;
  logic       new_over;
  logic       new_under;
  logic       over_now;
  logic       under_now;
  logic [7:0] tx_next;

  function automatic logic [6:0] tsa_addr_of(input logic [1:0] strap);
    logic [2:0] lo;
    case (strap)
      tsa_pkg::AS_GND: lo = ADDR_LO_GND;
      tsa_pkg::AS_VDD: lo = ADDR_LO_VDD;
      default:         lo = ADDR_LO_FLOAT;
    endcase
    return {tsa_pkg::ADDR_HI, lo};
  endfunction

  function automatic logic tsa_gt(input logic [7:0] a, input logic [7:0] b);
    return $signed(a) > $signed(b);
  endfunction

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q     <= 4'h3;
      sync_q     <= 4'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      meta_q     <= {addr_select_pin, sda_i, scl_i};
      sync_q     <= meta_q;
      scl_prev_q <= sync_q[0];
      sda_prev_q <= sync_q[1];
    end
  end

  always_comb begin
    scl_s     = sync_q[0];
    sda_s     = sync_q[1];
    scl_rise  = scl_s & ~scl_prev_q;
    scl_fall  = ~scl_s & scl_prev_q;
    start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    own_addr  = tsa_addr_of(sync_q[3:2]);
    addr_match = (rx_q[7:1] == own_addr);
    ara_match  = (rx_q[7:1] == tsa_pkg::ALERT_RSP_ADDR) & rx_q[0] & alert_q;
    ptr_wr    = (st_q == tsa_pkg::TSA_WR_BYTE) & scl_fall & (bit_cnt_q == tsa_pkg::BYTE_BITS) & first_q;
    data_wr   = (st_q == tsa_pkg::TSA_WR_BYTE) & scl_fall & (bit_cnt_q == tsa_pkg::BYTE_BITS) & ~first_q;
    load_evt  = scl_fall & (((st_q == tsa_pkg::TSA_ADDR_ACK) & rd_q) | ((st_q == tsa_pkg::TSA_RD_ACK) & ack_q));
    rd_temp2  = load_evt & ~ara_q & (ptr_q == tsa_pkg::PTR_TEMP) & second_q;
    // Conversions landing mid-transfer are dropped so a two-byte read stays coherent
    temp_take = temp_load & (st_q == tsa_pkg::TSA_IDLE);
    new_over  = tsa_gt(temp_code[tsa_pkg::TEMP_W-1:tsa_pkg::TEMP_INT_LSB], upper_temp_limit_q);
    new_under = tsa_gt(lower_temp_limit_q, temp_code[tsa_pkg::TEMP_W-1:tsa_pkg::TEMP_INT_LSB]);
    over_now  = tsa_gt(temp_q[tsa_pkg::TEMP_W-1:tsa_pkg::TEMP_INT_LSB], upper_temp_limit_q);
    under_now = tsa_gt(lower_temp_limit_q, temp_q[tsa_pkg::TEMP_W-1:tsa_pkg::TEMP_INT_LSB]);
    if (ara_q) begin
      tx_next = {own_addr, 1'b0};
    end else begin
      case (ptr_q)
        tsa_pkg::PTR_TEMP:  tx_next = second_q ?
                              {temp_q[1:0], alert_q, over_limit_bit_q, under_limit_bit_q, 3'h0} :
                              temp_q[tsa_pkg::TEMP_W-1:tsa_pkg::TEMP_INT_LSB];
        tsa_pkg::PTR_CFG:   tx_next = cfg_q;
        tsa_pkg::PTR_UPPER: tx_next = upper_temp_limit_q;
        default:            tx_next = lower_temp_limit_q;
      endcase
    end
  end

  // Bus protocol engine; sda only changes after a detected scl fall, start or stop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= tsa_pkg::TSA_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q      <= 8'h00;
      tx_q      <= 8'h00;
      rd_q      <= 1'b0;
      ara_q     <= 1'b0;
      first_q   <= 1'b0;
      ack_q     <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (start_det) begin
      st_q      <= tsa_pkg::TSA_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
    end else if (stop_det) begin
      st_q      <= tsa_pkg::TSA_IDLE;
      sda_oe_q  <= 1'b0;
    end else begin
      case (st_q)
        tsa_pkg::TSA_ADDR: begin
          if (scl_rise) begin
            rx_q      <= {rx_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == tsa_pkg::BYTE_BITS) begin
            if (addr_match || ara_match) begin
              sda_oe_q <= 1'b1;
              rd_q     <= rx_q[0];
              ara_q    <= ara_match;
              st_q     <= tsa_pkg::TSA_ADDR_ACK;
            end else begin
              st_q     <= tsa_pkg::TSA_IDLE;
            end
          end
        end
        tsa_pkg::TSA_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            first_q   <= 1'b1;
            if (rd_q) begin
              tx_q     <= tx_next;
              sda_oe_q <= ~tx_next[7];
              st_q     <= tsa_pkg::TSA_RD_BYTE;
            end else begin
              sda_oe_q <= 1'b0;
              st_q     <= tsa_pkg::TSA_WR_BYTE;
            end
          end
        end
        tsa_pkg::TSA_WR_BYTE: begin
          if (scl_rise) begin
            rx_q      <= {rx_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == tsa_pkg::BYTE_BITS) begin
            sda_oe_q <= 1'b1;
            first_q  <= 1'b0;
            st_q     <= tsa_pkg::TSA_WR_ACK;
          end
        end
        tsa_pkg::TSA_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_q  <= 1'b0;
            bit_cnt_q <= 4'h0;
            st_q      <= tsa_pkg::TSA_WR_BYTE;
          end
        end
        tsa_pkg::TSA_RD_BYTE: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            // Released a one but the line is low: another responder wins
            if (ara_q && tx_q[7] && !sda_s) begin
              st_q <= tsa_pkg::TSA_IDLE;
            end
          end else if (scl_fall) begin
            if (bit_cnt_q == tsa_pkg::BYTE_BITS) begin
              sda_oe_q <= 1'b0;
              st_q     <= tsa_pkg::TSA_RD_ACK;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
            end
          end
        end
        tsa_pkg::TSA_RD_ACK: begin
          if (scl_rise) begin
            ack_q <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (ack_q) begin
              tx_q     <= tx_next;
              sda_oe_q <= ~tx_next[7];
              st_q     <= tsa_pkg::TSA_RD_BYTE;
            end else begin
              st_q     <= tsa_pkg::TSA_IDLE;
            end
          end
        end
        default: begin
          st_q <= tsa_pkg::TSA_IDLE;
        end
      endcase
    end
  end

  // Byte order within a temperature read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      second_q <= 1'b0;
    end else if (start_det) begin
      second_q <= 1'b0;
    end else if (load_evt && !ara_q && ptr_q == tsa_pkg::PTR_TEMP) begin
      second_q <= ~second_q;
    end
  end

  // Register file
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q              <= tsa_pkg::PTR_RST;
      cfg_q              <= tsa_pkg::CFG_RST;
      upper_temp_limit_q <= tsa_pkg::UPPER_RST;
      lower_temp_limit_q <= tsa_pkg::LOWER_RST;
    end else if (ptr_wr) begin
      ptr_q <= rx_q[1:0];
    end else if (data_wr) begin
      case (ptr_q)
        tsa_pkg::PTR_CFG:   cfg_q              <= rx_q & tsa_pkg::CFG_STORE_MASK;
        tsa_pkg::PTR_UPPER: upper_temp_limit_q <= rx_q;
        tsa_pkg::PTR_LOWER: lower_temp_limit_q <= rx_q;
        default:            cfg_q              <= cfg_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_q <= '0;
    end else if (temp_take) begin
      temp_q <= temp_code;
    end
  end

  // Flags re-set while the condition holds; set beats the read clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      over_limit_bit_q  <= 1'b0;
      under_limit_bit_q <= 1'b0;
    end else begin
      over_limit_bit_q  <= over_now | (over_limit_bit_q & ~rd_temp2);
      under_limit_bit_q <= under_now | (under_limit_bit_q & ~rd_temp2);
    end
  end

  // Alert evaluated per conversion, so a D3 reset holds until the next one
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_q <= 1'b0;
    end else if (cfg_q[tsa_pkg::CFG_ALERT_DIS]) begin
      alert_q <= 1'b0;
    end else if (temp_take && new_over) begin
      alert_q <= 1'b1;
    end else if ((temp_take && new_under) || (data_wr && ptr_q == tsa_pkg::PTR_CFG && rx_q[tsa_pkg::CFG_ALERT_RST])) begin
      alert_q <= 1'b0;
    end
  end

  // Open-drain pins: only the enable moves, the data is always low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_oe_q <= 1'b0;
      alert_o_q  <= 1'b0;
      sda_o_q    <= 1'b0;
    end else begin
      alert_oe_q <= alert_q ^ cfg_q[tsa_pkg::CFG_ALERT_POL];
      alert_o_q  <= 1'b0;
      sda_o_q    <= 1'b0;
    end
  end

  assign sda_o    = sda_o_q;
  assign sda_oe   = sda_oe_q;
  assign alert_o  = alert_o_q;
  assign alert_oe = alert_oe_q;

  default clocking tsa_cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  alert_set_a: assert property (
    temp_take && new_over && !cfg_q[tsa_pkg::CFG_ALERT_DIS] |=> alert_q ##1 alert_oe_q != cfg_q[tsa_pkg::CFG_ALERT_POL])
    else $error("alert not raised above upper limit");
  alert_clear_a: assert property (
    temp_take && new_under && !new_over |=> !alert_q)
    else $error("alert not cleared below lower limit");
  alert_disable_a: assert property (
    cfg_q[tsa_pkg::CFG_ALERT_DIS] |=> !alert_q)
    else $error("alert active while disabled");
  alert_rst_a: assert property (
    data_wr && ptr_q == tsa_pkg::PTR_CFG && rx_q[tsa_pkg::CFG_ALERT_RST] && !(temp_take && new_over) |=> !alert_q)
    else $error("alert reset bit ignored");
  od_pins_a: assert property (
    !alert_o && !sda_o)
    else $error("open-drain data driven high");
  addr_ack_a: assert property (
    st_q == tsa_pkg::TSA_ADDR && scl_fall && bit_cnt_q == tsa_pkg::BYTE_BITS && addr_match |=> sda_oe ##1 sda_oe)
    else $error("address not acknowledged");
  sda_timing_a: assert property (
    $changed(sda_oe_q) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
    else $error("sda moved outside scl low");
  ptr_only_a: assert property (
    ptr_wr |=> $stable(cfg_q) && $stable(upper_temp_limit_q) && $stable(lower_temp_limit_q) && ptr_q == $past(rx_q[1:0]))
    else $error("pointer write disturbed data");
  upper_store_a: assert property (
    data_wr && ptr_q == tsa_pkg::PTR_UPPER |=> upper_temp_limit_q == $past(rx_q) && $stable(ptr_q))
    else $error("upper limit write lost");
  ro_temp_a: assert property (
    data_wr && ptr_q == tsa_pkg::PTR_TEMP |=> $stable(cfg_q) && $stable(upper_temp_limit_q) && $stable(lower_temp_limit_q))
    else $error("read-only write changed state");
  flag_clr_a: assert property (
    rd_temp2 && !over_now |=> !over_limit_bit_q)
    else $error("over flag not cleared by read");
  ara_ack_a: assert property (
    st_q == tsa_pkg::TSA_ADDR_ACK && ara_q |-> $past(alert_q))
    else $error("alert response acknowledged without alert");

  two_byte_c: cover property (rd_temp2);
  alert_up_c: cover property (!alert_q ##1 alert_q);
  ara_c:      cover property (st_q == tsa_pkg::TSA_ADDR_ACK && ara_q);
  cfg_wr_c:   cover property (data_wr && ptr_q == tsa_pkg::PTR_CFG);

endmodule

// File: src/tsa_pkg.sv
// Shared constants and types for the temperature sensor two-wire slave with limit alert.
// Assumes a single 100 MHz ref_clk domain; bus pins and the address strap are synchronised by the user module.
package tsa_pkg;

  // Register pointer values, two bits wide
  localparam logic [1:0] PTR_TEMP    = 2'h0;
  localparam logic [1:0] PTR_CFG     = 2'h1;
  localparam logic [1:0] PTR_UPPER   = 2'h2;
  localparam logic [1:0] PTR_LOWER   = 2'h3;
  localparam logic [1:0] PTR_RST     = PTR_TEMP;

  // Power-up values
  localparam logic [7:0] UPPER_RST   = 8'h7f;
  localparam logic [7:0] LOWER_RST   = 8'h80;
  localparam logic [7:0] CFG_RST     = 8'h40;

  // Configuration field positions
  localparam int         CFG_ALERT_DIS = 5;
  localparam int         CFG_ALERT_POL = 4;
  localparam int         CFG_ALERT_RST = 3;
  // Action bits D3 and D2 are not stored and read back as zero
  localparam logic [7:0] CFG_STORE_MASK = 8'hf3;

  // Temperature value width and second-byte layout
  localparam int         TEMP_W       = 10;
  localparam int         TEMP_INT_LSB = 2;

  // Bus addressing
  localparam logic [3:0] ADDR_HI      = 4'h9;
  localparam logic [6:0] ALERT_RSP_ADDR = 7'h0c;

  // Address select strap encodings
  localparam logic [1:0] AS_GND       = 2'h0;
  localparam logic [1:0] AS_VDD       = 2'h1;
  localparam logic [1:0] AS_FLOAT     = 2'h2;

  // Bits per byte on the wire
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  typedef enum logic [2:0] {
    TSA_IDLE,
    TSA_ADDR,
    TSA_ADDR_ACK,
    TSA_WR_BYTE,
    TSA_WR_ACK,
    TSA_RD_BYTE,
    TSA_RD_ACK
  } tsa_state_t;

endpackage

// File: tb/tsa_master_model.sv
// Behavioural two-wire bus master that stands on the far side of the sensor slave.
// Assumes the bench resolves the shared data wire with a pull-up and feeds it back on sda_i.
`timescale 1ns/100ps
module tsa_master_model (
  output logic      scl_o,
  output logic      sda_drv,
  input  wire logic sda_i
);
  // Quarter of the 125 ns bus clock period; the clock stands high between frames
  localparam realtime QTR = 31.25;

  initial begin
    scl_o   = 1'b1;
    sda_drv = 1'b0;
  end

  // Also a repeated start: data is released while the clock is low, then falls with the clock high
  task automatic start_cond();
    sda_drv = 1'b0;
    #QTR;
    scl_o = 1'b1;
    #(2*QTR);
    sda_drv = 1'b1;
    #(2*QTR);
    scl_o = 1'b0;
    #QTR;
  endtask

  task automatic stop_cond();
    sda_drv = 1'b1;
    #QTR;
    scl_o = 1'b1;
    #(2*QTR);
    sda_drv = 1'b0;
    #(2*QTR);
  endtask

  // Data changes a quarter period into the low phase and holds through the high phase
  task automatic bit_xfer(input logic b, output logic s);
    sda_drv = !b;
    #QTR;
    scl_o = 1'b1;
    #QTR;
    s = sda_i;
    #QTR;
    scl_o = 1'b0;
    #QTR;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
    end
    bit_xfer(1'b1, s);
    ack = !s;
  endtask

  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(!ack, s);
  endtask

  task automatic wr_xfer(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                         input logic with_d, output logic ok);
    logic k;
    start_cond();
    put_byte({a, 1'b0}, ok);
    put_byte(p, k);
    ok = ok & k;
    if (with_d) begin
      put_byte(d, k);
      ok = ok & k;
    end
    stop_cond();
  endtask

  // Last byte is not acknowledged so the slave lets go before the stop
  task automatic rd_xfer(input logic [6:0] a, input int n, output logic ok, output logic [15:0] v);
    logic [7:0] b;
    v = 16'h0000;
    start_cond();
    put_byte({a, 1'b1}, ok);
    if (ok) begin
      for (int i = 0; i < n; i++) begin
        get_byte(i < n - 1, b);
        v = {v[7:0], b};
      end
    end
    stop_cond();
  endtask
endmodule

// File: tb/tsa_i2c_slave_test.sv
// Self-checking bench for the sensor slave: bus traffic from the master model, temperature loads from here.
// Assumes open-drain data and alert wires with pull-ups, resolved below.
`timescale 1ns/100ps
module tsa_i2c_slave_test;
  localparam logic [2:0] LO_GND   = 3'h0;
  localparam logic [2:0] LO_VDD   = 3'h1;
  localparam logic [2:0] LO_FLOAT = 3'h2;
  localparam int         CEIL     = 60000;

  logic                       ref_clk;
  logic                       arst_n;
  logic                       temp_load;
  logic [1:0]                 strap;
  logic [tsa_pkg::TEMP_W-1:0] temp_code;
  logic                       scl;
  logic                       m_sda;
  logic                       sda_o;
  logic                       sda_oe;
  logic                       alert_o;
  logic                       alert_oe;
  logic                       sda_w;
  logic                       alert_pin;
  logic [6:0]                 own;
  int                         bad_count;
  int                         compares;
  int                         cycles;

  assign sda_w     = (m_sda || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  assign alert_pin = (alert_oe && !alert_o) ? 1'b0 : 1'b1;

  tsa_master_model mst (.scl_o(scl), .sda_drv(m_sda), .sda_i(sda_w));

  tsa_i2c_slave #(.ADDR_LO_GND(LO_GND), .ADDR_LO_VDD(LO_VDD), .ADDR_LO_FLOAT(LO_FLOAT)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_select_pin(strap), .temp_code(temp_code), .temp_load(temp_load), .alert_o(alert_o),
    .alert_oe(alert_oe));

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Ceiling on the whole run; the master model waits on fixed delays only and always returns
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == CEIL) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic with_d);
    logic ok;
    mst.wr_xfer(own, p, d, with_d, ok);
    check({15'h0000, ok}, 16'h0001);
  endtask

  task automatic rd(input int n, input logic [15:0] exp);
    logic        ok;
    logic [15:0] v;
    mst.rd_xfer(own, n, ok, v);
    check({15'h0000, ok}, 16'h0001);
    check(v, exp);
  endtask

  // Loads are only taken while the bus is idle, so every caller runs between frames
  task automatic load(input logic [tsa_pkg::TEMP_W-1:0] t);
    @(posedge ref_clk);
    #1;
    temp_code = t;
    temp_load = 1'b1;
    @(posedge ref_clk);
    #1;
    temp_load = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic alert_is(input logic exp_oe);
    check({15'h0000, alert_oe}, {15'h0000, exp_oe});
    check({15'h0000, alert_pin}, {15'h0000, !exp_oe});
  endtask

  task automatic ara(input logic exp_ack);
    logic        ok;
    logic [15:0] v;
    mst.rd_xfer(7'h0c, 1, ok, v);
    check({15'h0000, ok}, {15'h0000, exp_ack});
    if (exp_ack) begin
      check(v, {8'h00, own, 1'b0});
    end
  endtask

  task automatic s_reset();
    logic [7:0] dflt [1:3];
    dflt = '{8'h40, 8'h7f, 8'h80};
    rd(2, 16'h0000);
    load(10'h065);
    rd(2, 16'h1940);
    for (int i = 1; i < 4; i++) begin
      wr(8'(i), 8'h00, 1'b0);
      rd(1, {8'h00, dflt[i]});
      rd(1, {8'h00, dflt[i]});
    end
  endtask

  task automatic s_regs();
    wr(8'h02, 8'h1e, 1'b1);
    wr(8'h03, 8'h14, 1'b1);
    wr(8'h01, 8'h48, 1'b1);
    rd(1, 16'h0040);
    wr(8'h02, 8'h00, 1'b0);
    rd(1, 16'h001e);
    wr(8'h03, 8'h00, 1'b0);
    rd(1, 16'h0014);
    wr(8'h00, 8'h55, 1'b1);
    rd(2, 16'h1940);
  endtask

  task automatic s_alert();
    load(10'h07c);
    alert_is(1'b1);
    rd(2, 16'h1f30);
    ara(1'b1);
    load(10'h064);
    alert_is(1'b1);
    // Over flag is sticky until the second byte is read once
    rd(2, 16'h1930);
    rd(2, 16'h1920);
    load(10'h04c);
    alert_is(1'b0);
    ara(1'b0);
    wr(8'h03, 8'hf6, 1'b1);
    load(10'h3ec);
    alert_is(1'b0);
    load(10'h07c);
    load(10'h3d0);
    alert_is(1'b0);
  endtask

  task automatic s_pol();
    load(10'h07c);
    alert_is(1'b1);
    wr(8'h01, 8'h50, 1'b1);
    alert_is(1'b0);
    wr(8'h01, 8'h58, 1'b1);
    alert_is(1'b1);
    wr(8'h01, 8'h60, 1'b1);
    load(10'h07c);
    alert_is(1'b0);
    wr(8'h01, 8'h40, 1'b1);
    load(10'h07c);
    alert_is(1'b1);
    load(10'h3d0);
    alert_is(1'b0);
  endtask

  task automatic s_addr();
    logic       ok;
    logic [2:0] lo;
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      #1;
      strap = 2'(s);
      lo    = (s == 0) ? LO_GND : (s == 1) ? LO_VDD : LO_FLOAT;
      own   = {4'h9, lo};
      repeat (8) @(posedge ref_clk);
      wr(8'h01, 8'h00, 1'b0);
      mst.wr_xfer({4'h8, lo}, 8'h01, 8'h00, 1'b0, ok);
      check({15'h0000, ok}, 16'h0000);
      mst.wr_xfer({4'h9, (lo == LO_GND) ? LO_VDD : LO_GND}, 8'h01, 8'h00, 1'b0, ok);
      check({15'h0000, ok}, 16'h0000);
    end
  endtask

  initial begin
    arst_n    = 1'b0;
    temp_load = 1'b0;
    temp_code = '0;
    strap     = 2'h0;
    own       = {4'h9, LO_GND};
    bad_count = 0;
    compares  = 0;
    cycles    = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    repeat (5) @(posedge ref_clk);
    s_reset();
    s_regs();
    s_alert();
    s_pol();
    s_addr();
    give_verdict();
  end
endmodule
